// [design/cc_module.sv]
// One capture/compare module working off the shared time base
`timescale 1ns/1ps
`default_nettype none
module cc_module import ca_pkg::*; #(
  parameter bit WATCHDOG_CAPABLE = 1'b0 // Module may run as watchdog
) (
  input wire logic clock, // System clock
  input wire logic rst, // Asynchronous reset, active high
  cc_if.cc bus // Link to the time base
);
  // Reset values differ for the watchdog-capable module
  localparam logic [DATA_W-1:0] MODE_INIT = WATCHDOG_CAPABLE ? MODE_RESET_WDG : 8'h00;
  localparam logic [COUNT_W-1:0] CMP_INIT = WATCHDOG_CAPABLE ? CMP_RESET_WDG : 16'h0000;

  logic [DATA_W-1:0] mode_q, mode_d; // Mode register
  logic [COUNT_W-1:0] cmp_q, cmp_d; // Compare/capture register
  logic out_q, out_d; // Pin output
  logic oe_q, oe_d; // Pin output enable
  logic hit_q, hit_d; // Event pulse
  logic prev_q, prev_d; // Pin input one cycle ago
  mode_e mode; // Decoded mode
  logic match; // Full compare match on a tick

  // Mode decode, watchdog code is inert on ordinary modules
  always_comb begin
    mode = mode_e'(mode_q[2:0]);
    if (mode == MODE_WATCHDOG && !WATCHDOG_CAPABLE) begin
      mode = MODE_OFF;
    end
    match = bus.tick && (bus.count == cmp_q);
  end

  // Next state of the module
  always_comb begin
    mode_d = mode_q;
    cmp_d = cmp_q;
    out_d = out_q;
    hit_d = 1'b0;
    prev_d = bus.pin_in;
    oe_d = 1'b0;
    if (bus.wr_mode) begin
      mode_d = bus.wdata & MODE_MASK;
    end
    if (bus.wr_lo) begin
      cmp_d[7:0] = bus.wdata;
    end
    if (bus.wr_hi) begin
      cmp_d[15:8] = bus.wdata;
    end
    case (mode)
      MODE_CAPTURE: begin
        // Input edge latches the time base
        if ((bus.pin_in && !prev_q && mode_q[MODE_RISE]) ||
            (!bus.pin_in && prev_q && mode_q[MODE_FALL])) begin
          cmp_d = bus.count;
          hit_d = 1'b1;
        end
      end
      MODE_TIMER: begin
        hit_d = match;
      end
      MODE_HSO: begin
        // Toggle the pin on every match
        oe_d = 1'b1;
        if (match) begin
          hit_d = 1'b1;
          out_d = !out_q;
        end
      end
      MODE_PWM8: begin
        // Duty from the high byte against the low count byte
        oe_d = 1'b1;
        out_d = bus.count[7:0] < cmp_q[15:8];
      end
      MODE_PWM16: begin
        oe_d = 1'b1;
        out_d = bus.count < cmp_q;
        hit_d = match;
      end
      MODE_FREQ: begin
        // Low byte steps ahead by the high byte after each toggle
        oe_d = 1'b1;
        if (bus.tick && bus.count[7:0] == cmp_q[7:0]) begin
          out_d = !out_q;
          cmp_d[7:0] = cmp_q[7:0] + cmp_q[15:8];
        end
      end
      MODE_WATCHDOG: begin
        // Kick pushes the deadline out by the low byte offset
        if (bus.kick) begin
          cmp_d[15:8] = bus.count[15:8] + cmp_q[7:0];
        end else if (bus.tick && bus.count[15:8] == cmp_q[15:8]) begin
          hit_d = 1'b1;
        end
      end
      default: begin
        out_d = 1'b0; // Idle output low
      end
    endcase
  end

  // Register the module state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_INIT;
      cmp_q <= CMP_INIT;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      hit_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cmp_q <= cmp_d;
      out_q <= out_d;
      oe_q <= oe_d;
      hit_q <= hit_d;
      prev_q <= prev_d;
    end
  end

  assign bus.mode = mode_q;
  assign bus.cmp = cmp_q;
  assign bus.hit = hit_q;
  assign bus.pin_out = out_q;
  assign bus.pin_oe = oe_q;
endmodule // cc_module
`default_nettype wire

// [design/counter_array.sv]
// Counter array top: shared time base, registers and three modules
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module counter_array import ca_pkg::*; #(
  parameter int MODULES = NUM_MODULES // Capture/compare module count
) (
  input wire logic clock, // System clock, 200 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [DATA_W-1:0] wdata, // Register write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [DATA_W-1:0] rdata, // Read data, cycle after rd
  input wire logic timer0_overflow, // Timer 0 overflow pulse
  input wire logic external_count_input, // Count input from crossbar
  input wire logic ext_osc_clock, // External oscillator level
  input wire logic [MODULES-1:0] module_in, // Module inputs from crossbar
  output logic [MODULES-1:0] module_out, // Module outputs to crossbar
  output logic [MODULES-1:0] module_oe, // Module output enables
  output logic irq, // Level interrupt
  output logic watchdog_reset // Watchdog timeout pulse
);
  localparam int SW = MODULES + 1; // Status width

  logic [DATA_W-1:0] ctrl_q, ctrl_d; // Run and clock select
  logic [COUNT_W-1:0] count_q, count_d; // Shared time base
  logic [3:0] slow_q, slow_d; // Divide-by-slow prescaler
  logic [1:0] fast_q, fast_d; // Divide-by-fast prescaler
  logic [2:0] ext_q, ext_d; // External oscillator edge counter
  logic ext_prev_q, ext_prev_d; // Oscillator level last cycle
  logic eci_prev_q, eci_prev_d; // Count input level last cycle
  logic [SW-1:0] status_q, status_d; // Sticky events
  logic [SW-1:0] mask_q, mask_d; // Interrupt mask
  logic [DATA_W-1:0] rdata_q, rdata_d; // Read data register
  logic irq_q, irq_d; // Interrupt output register
  logic wdog_q, wdog_d; // Watchdog timeout register
  logic tick; // Time base advances this cycle
  logic ovf; // Time base wraps this cycle
  logic ext_rise; // Oscillator rising edge
  logic eci_rise; // Count input rising edge
  logic [SW-1:0] events; // Event pulses this cycle
  src_e src; // Selected clock source
  logic [DATA_W-1:0] mode_arr [MODULES]; // Module mode copies
  logic [COUNT_W-1:0] cmp_arr [MODULES]; // Module compare copies
  logic [MODULES-1:0] hit_vec; // Module event pulses

  cc_if mif [MODULES] (); // One link per module

  // Source edges from synchronous inputs
  always_comb begin
    ext_rise = ext_osc_clock && !ext_prev_q;
    eci_rise = external_count_input && !eci_prev_q;
    src = src_e'(ctrl_q[CTRL_SEL_LSB +: 3]);
  end

  // Prescalers free-run so a source switch takes effect at once
  always_comb begin
    slow_d = (slow_q == 4'(DIV_SLOW - 1)) ? 4'h0 : slow_q + 4'h1;
    fast_d = (fast_q == 2'(DIV_FAST - 1)) ? 2'h0 : fast_q + 2'h1;
    ext_d = ext_q;
    if (ext_rise) begin
      ext_d = (ext_q == 3'(DIV_EXT - 1)) ? 3'h0 : ext_q + 3'h1;
    end
    ext_prev_d = ext_osc_clock;
    eci_prev_d = external_count_input;
  end

  // Clock source select
  always_comb begin
    tick = 1'b0;
    case (src)
      SRC_DIV_SLOW: tick = (slow_q == 4'(DIV_SLOW - 1));
      SRC_DIV_FAST: tick = (fast_q == 2'(DIV_FAST - 1));
      SRC_TIMER0: tick = timer0_overflow;
      SRC_EXT_COUNT: tick = eci_rise;
      SRC_SYS: tick = 1'b1;
      SRC_EXT_OSC: tick = ext_rise && (ext_q == 3'(DIV_EXT - 1));
      default: tick = 1'b0; // Unused codes stop the time base
    endcase
    tick = tick && ctrl_q[CTRL_RUN];
  end

  // Time base next value; software write wins over counting
  always_comb begin
    count_d = count_q;
    ovf = tick && (count_q == 16'hffff);
    if (tick) begin
      count_d = count_q + 16'h0001;
    end
    if (wr && addr == ADDR_COUNT_LO) begin
      count_d[7:0] = wdata;
    end
    if (wr && addr == ADDR_COUNT_HI) begin
      count_d[15:8] = wdata;
    end
  end

  // Per-module links and instances
  genvar i;
  generate
    for (i = 0; i < MODULES; i++) begin : g_mod
      localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'(MOD_BASE + i * MOD_STRIDE + OFF_MODE);
      localparam logic [ADDR_W-1:0] A_LO = ADDR_W'(MOD_BASE + i * MOD_STRIDE + OFF_CMP_LO);
      localparam logic [ADDR_W-1:0] A_HI = ADDR_W'(MOD_BASE + i * MOD_STRIDE + OFF_CMP_HI);
      // Every module sees the same count and tick
      assign mif[i].count = count_q;
      assign mif[i].tick = tick;
      assign mif[i].wdata = wdata;
      assign mif[i].wr_mode = wr && (addr == A_MODE);
      assign mif[i].wr_lo = wr && (addr == A_LO);
      assign mif[i].wr_hi = wr && (addr == A_HI);
      assign mif[i].kick = wr && (addr == ADDR_KICK) && (i == WDG_INDEX);
      assign mif[i].pin_in = module_in[i];
      assign mode_arr[i] = mif[i].mode;
      assign cmp_arr[i] = mif[i].cmp;
      assign hit_vec[i] = mif[i].hit;
      // Pins leave only toward the crossbar
      assign module_out[i] = mif[i].pin_out;
      assign module_oe[i] = mif[i].pin_oe;
      cc_module #(
        .WATCHDOG_CAPABLE(i == WDG_INDEX)
      ) u_cc (
        .clock(clock),
        .rst(rst),
        .bus(mif[i])
      );
    end
  endgenerate

  // Control, mask, status and interrupt next values
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (wr && addr == ADDR_CTRL) begin
      ctrl_d = wdata & CTRL_MASK;
    end
    if (wr && addr == ADDR_MASK) begin
      mask_d = wdata[SW-1:0];
    end
    events = {hit_vec, ovf};
    status_d = status_q;
    if (rd && addr == ADDR_STATUS) begin
      status_d = '0; // Read clears
    end
    status_d = status_d | events; // New event beats the clear
    irq_d = |(status_d & mask_d);
    // Timeout only counts while module 2 is in watchdog mode
    wdog_d = hit_vec[WDG_INDEX] &&
             (mode_arr[WDG_INDEX][2:0] == MODE_WATCHDOG);
  end

  // Read data decode, zero for unmapped addresses
  always_comb begin
    rdata_d = '0;
    if (!rd) begin
      rdata_d = '0; // Data stand only after a read
    end else if (addr == ADDR_CTRL) begin
      rdata_d = ctrl_q;
    end else if (addr == ADDR_COUNT_LO) begin
      rdata_d = count_q[7:0];
    end else if (addr == ADDR_COUNT_HI) begin
      rdata_d = count_q[15:8];
    end else if (addr == ADDR_STATUS) begin
      rdata_d = DATA_W'(status_q);
    end else if (addr == ADDR_MASK) begin
      rdata_d = DATA_W'(mask_q);
    end else begin
      // Module registers by stride
      for (int m = 0; m < MODULES; m++) begin
        if (addr == ADDR_W'(MOD_BASE + m * MOD_STRIDE + OFF_MODE)) begin
          rdata_d = mode_arr[m];
        end else if (addr == ADDR_W'(MOD_BASE + m * MOD_STRIDE + OFF_CMP_LO)) begin
          rdata_d = cmp_arr[m][7:0];
        end else if (addr == ADDR_W'(MOD_BASE + m * MOD_STRIDE + OFF_CMP_HI)) begin
          rdata_d = cmp_arr[m][15:8];
        end
      end
    end
  end

  // Register all top-level state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      count_q <= 16'h0000;
      slow_q <= 4'h0;
      fast_q <= 2'h0;
      ext_q <= 3'h0;
      ext_prev_q <= 1'b0;
      eci_prev_q <= 1'b0;
      status_q <= '0;
      mask_q <= '0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      wdog_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      slow_q <= slow_d;
      fast_q <= fast_d;
      ext_q <= ext_d;
      ext_prev_q <= ext_prev_d;
      eci_prev_q <= eci_prev_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      wdog_q <= wdog_d;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign watchdog_reset = wdog_q;
endmodule // counter_array
`default_nettype wire

// [include/ca_pkg.sv]
// Shared constants, register map and types of the counter array
package ca_pkg;
  localparam int COUNT_W = 16; // Time base width
  localparam int NUM_MODULES = 3; // Capture/compare modules
  localparam int WDG_INDEX = 2; // Module that can act as watchdog
  localparam int ADDR_W = 5; // Register address width
  localparam int DATA_W = 8; // Register data width
  localparam int DIV_SLOW = 12; // System clock divider, slow source
  localparam int DIV_FAST = 4; // System clock divider, fast source
  localparam int DIV_EXT = 8; // External oscillator divider
  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00; // Run and clock select
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LO = 5'h01; // Time base low byte
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HI = 5'h02; // Time base high byte
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h03; // Sticky events, read clears
  localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h04; // Interrupt mask
  localparam logic [ADDR_W-1:0] ADDR_KICK = 5'h05; // Watchdog restart strobe
  localparam int MOD_BASE = 8; // First module register
  localparam int MOD_STRIDE = 4; // Address step between modules
  localparam int OFF_MODE = 0; // Module mode register
  localparam int OFF_CMP_LO = 1; // Module compare/capture low byte
  localparam int OFF_CMP_HI = 2; // Module compare/capture high byte
  // Control fields and reset value
  localparam int CTRL_RUN = 0; // Time base runs when set
  localparam int CTRL_SEL_LSB = 1; // Clock select field
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h01; // Running, slow source
  localparam logic [DATA_W-1:0] CTRL_MASK = 8'h0f; // Implemented control bits
  // Status bit positions
  localparam int ST_OVF = 0; // Time base wrapped
  localparam int ST_MOD_LSB = 1; // First module event bit
  localparam int ST_W = NUM_MODULES + 1; // Implemented status bits
  // Mode register fields
  localparam int MODE_RISE = 3; // Capture on rising edge
  localparam int MODE_FALL = 4; // Capture on falling edge
  localparam logic [DATA_W-1:0] MODE_MASK = 8'h1f; // Implemented mode bits
  // Time base clock sources
  typedef enum logic [2:0] {
    SRC_DIV_SLOW = 3'h0, SRC_DIV_FAST = 3'h1, SRC_TIMER0 = 3'h2,
    SRC_EXT_COUNT = 3'h3, SRC_SYS = 3'h4, SRC_EXT_OSC = 3'h5
  } src_e;
  // Module modes, Gray coded
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, MODE_CAPTURE = 3'h1, MODE_TIMER = 3'h3, MODE_HSO = 3'h2,
    MODE_PWM8 = 3'h6, MODE_PWM16 = 3'h7, MODE_FREQ = 3'h5, MODE_WATCHDOG = 3'h4
  } mode_e;
  localparam logic [DATA_W-1:0] MODE_RESET_WDG = 8'h04; // Watchdog mode code
  localparam logic [COUNT_W-1:0] CMP_RESET_WDG = 16'hffff; // Longest timeout
endpackage

// [include/cc_if.sv]
// Link between the time base and one capture/compare module
`timescale 1ns/1ps
`default_nettype none
interface cc_if;
  import ca_pkg::*;
  logic [COUNT_W-1:0] count; // Current time base value
  logic tick; // Time base advances this cycle
  logic wr_mode; // Write strobe, mode register
  logic wr_lo; // Write strobe, compare low byte
  logic wr_hi; // Write strobe, compare high byte
  logic kick; // Watchdog restart strobe
  logic [DATA_W-1:0] wdata; // Write data
  logic pin_in; // Module input from crossbar
  logic [DATA_W-1:0] mode; // Mode register value
  logic [COUNT_W-1:0] cmp; // Compare/capture value
  logic hit; // Module event pulse
  logic pin_out; // Module output to crossbar
  logic pin_oe; // Module drives its pin
  modport top (output count, tick, wr_mode, wr_lo, wr_hi, kick, wdata, pin_in,
               input mode, cmp, hit, pin_out, pin_oe);
  modport cc (input count, tick, wr_mode, wr_lo, wr_hi, kick, wdata, pin_in,
              output mode, cmp, hit, pin_out, pin_oe);
endinterface
`default_nettype wire

// [tb/counter_array_sva.sv]
// Port-level checker for the counter array
`timescale 1ns/1ps
`default_nettype none
module counter_array_sva import ca_pkg::*; #(
  parameter int MODULES = NUM_MODULES // Module count
) (
  input wire logic clock, // System clock
  input wire logic rst, // Reset, active high
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [DATA_W-1:0] rdata, // Read data
  input wire logic [MODULES-1:0] module_oe, // Output enables
  input wire logic irq, // Level interrupt
  input wire logic watchdog_reset // Watchdog pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [DATA_W-1:0] ctrl_q, ctrl_d; // Shadow of control
  logic [DATA_W-1:0] mask_q, mask_d; // Shadow of mask
  // Shadow next values follow the write strobe
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (wr && addr == ADDR_CTRL) begin
      ctrl_d = wdata & CTRL_MASK;
    end
    if (wr && addr == ADDR_MASK) begin
      mask_d = wdata & 8'h0f;
    end
  end
  // Shadows start from the block's reset values
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end
  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == 8'h00) else $error("rdata not zero outside read");
  ctrl_read_a: assert property (
    $past(rd && addr == ADDR_CTRL) |-> rdata == $past(ctrl_q)) else $error("ctrl readback");
  mask_read_a: assert property (
    $past(rd && addr == ADDR_MASK) |-> rdata == $past(mask_q)) else $error("mask readback");
  unmapped_read_a: assert property (
    $past(rd && (addr inside {5'h06, 5'h07, 5'h0b, 5'h0f} || addr >= 5'h13))
    |-> rdata == 8'h00) else $error("unmapped read not zero");
  mode_resv_a: assert property (
    $past(rd && addr >= 5'h08 && addr[1:0] == 2'b00) |-> rdata[7:5] == 3'h0)
    else $error("mode reserved bits set");
  reset_outs_a: assert property (
    $past(rst) |-> !irq && !watchdog_reset && module_oe == '0) else $error("outputs after reset");
  irq_masked_a: assert property (
    mask_q == 8'h00 |-> !irq) else $error("irq with mask clear");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(rd && addr == ADDR_STATUS) || $past(wr && addr == ADDR_MASK))
    else $error("irq fell without cause");
  wdg_run_a: assert property (
    watchdog_reset |-> $past(ctrl_q[CTRL_RUN], 1) || $past(ctrl_q[CTRL_RUN], 2)
    || $past(ctrl_q[CTRL_RUN], 3) || $past(ctrl_q[CTRL_RUN], 4)) else $error("watchdog idle");
  wdg_irq_a: assert property (
    watchdog_reset && mask_q[ST_MOD_LSB + WDG_INDEX] |-> irq) else $error("watchdog irq");
endmodule // counter_array_sva
bind counter_array counter_array_sva #(.MODULES(MODULES)) i_sva (
  .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .module_oe(module_oe), .irq(irq), .watchdog_reset(watchdog_reset)
);
`default_nettype wire

// [tb/counter_array_tb_top.sv]
// Self-checking bench for the counter array
`timescale 1ns/1ps
`default_nettype none
module counter_array_tb_top import ca_pkg::*; ();
  localparam logic [4:0] M0 = 5'(MOD_BASE); // Module 0 mode
  localparam logic [4:0] M1 = 5'(MOD_BASE + MOD_STRIDE); // Module 1 mode
  localparam logic [4:0] M2 = 5'(MOD_BASE + MOD_STRIDE * WDG_INDEX); // Module 2 mode
  logic clock = 1'b0; // System clock
  logic rst; // Reset, raised at time zero
  logic [4:0] addr = 5'h00; // Register address
  logic [7:0] wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [2:0] pin_drive = 3'h0; // Bench pin levels
  logic [7:0] rdata; // Read data
  logic t0, ext_cnt, osc, irq, wdg; // Sources and flags
  logic [2:0] mod_in, mod_out, mod_oe; // Pin signals
  int err_count = 0; // Mismatches
  int compares = 0; // Comparisons
  int wdg_seen = 0; // Watchdog pulses seen
  // 200 MHz clock
  always #2.5 clock = ~clock;
  // Count watchdog pulses as they stand
  always @(posedge clock) begin
    if (wdg === 1'b1) begin
      wdg_seen++;
    end
  end
  counter_array #(.MODULES(3)) i_dut (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer0_overflow(t0), .external_count_input(ext_cnt),
    .ext_osc_clock(osc), .module_in(mod_in), .module_out(mod_out),
    .module_oe(mod_oe), .irq(irq), .watchdog_reset(wdg)
  );
  crossbar_model i_far (
    .clock(clock), .rst(rst), .pin_drive(pin_drive), .module_out(mod_out),
    .module_oe(mod_oe), .timer0_overflow(t0), .external_count_input(ext_cnt),
    .ext_osc_clock(osc), .module_in(mod_in)
  );
  // Compare one byte, four-state exact
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle register write
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read, then judge the data in the following cycle
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check8(what, exp, rdata);
  endtask
  // Verdict, reached once
  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Values straight out of reset
  task automatic reset_values();
    rd_chk("ctrl", ADDR_CTRL, CTRL_RESET);
    rd_chk("mode2", M2, MODE_RESET_WDG);
    rd_chk("cmp2 lo", M2 + 5'h01, CMP_RESET_WDG[7:0]);
    rd_chk("cmp2 hi", M2 + 5'h02, CMP_RESET_WDG[15:8]);
    rd_chk("mask", ADDR_MASK, 8'h00);
    rd_chk("unmapped", 5'h1f, 8'h00);
    $display("test reset_values done");
  endtask
  // Each source over a 48-cycle run window; code 6 must hold the count still
  task automatic sources();
    logic [7:0] exp [7];
    exp = '{8'(48 / DIV_SLOW), 8'(48 / DIV_FAST), 8'h10, 8'h0c, 8'h30,
            8'(48 / (2 * DIV_EXT)), 8'h00};
    for (int s = 0; s < 7; s++) begin
      wr_reg(ADDR_CTRL, 8'(s * 2));
      wr_reg(ADDR_COUNT_LO, 8'h00);
      wr_reg(ADDR_COUNT_HI, 8'h00);
      wr_reg(ADDR_CTRL, 8'(s * 2 + 1));
      repeat (46) @(posedge clock);
      wr_reg(ADDR_CTRL, 8'(s * 2));
      rd_chk("count lo", ADDR_COUNT_LO, exp[s]);
    end
    $display("test sources done");
  endtask
  // Wrap through the top with the watchdog armed
  task automatic wrap_watchdog();
    wr_reg(ADDR_MASK, 8'h09);
    wr_reg(ADDR_CTRL, 8'h08);
    wr_reg(ADDR_COUNT_LO, 8'hfe);
    wr_reg(ADDR_COUNT_HI, 8'hff);
    wdg_seen = 0;
    wr_reg(ADDR_CTRL, 8'h09);
    wr_reg(ADDR_CTRL, 8'h08);
    repeat (4) @(posedge clock);
    #1;
    check8("irq", 8'h01, {7'h00, irq});
    check8("wdg pulses", 8'h02, 8'(wdg_seen));
    rd_chk("status", ADDR_STATUS, 8'h09);
    rd_chk("status", ADDR_STATUS, 8'h00);
    check8("irq", 8'h00, {7'h00, irq});
    rd_chk("count lo", ADDR_COUNT_LO, 8'h00);
    rd_chk("count hi", ADDR_COUNT_HI, 8'h00);
    $display("test wrap_watchdog done");
  endtask
  // Restart moves the deadline from the count
  task automatic kick();
    wr_reg(ADDR_COUNT_HI, 8'h10);
    wr_reg(M2 + 5'h01, 8'h05);
    wr_reg(ADDR_KICK, 8'h00);
    rd_chk("cmp2 hi", M2 + 5'h02, 8'h15);
    $display("test kick done");
  endtask
  // Every mode code on module 0, pin drive per mode
  task automatic mode_sweep();
    mode_e m;
    m = m.first();
    repeat (8) begin
      wr_reg(M0, {5'h00, m});
      rd_chk("mode0", M0, {5'h00, m});
      check8("oe0", {7'h00, m inside {MODE_HSO, MODE_PWM8, MODE_PWM16, MODE_FREQ}},
             {7'h00, mod_oe[0]});
      m = m.next();
    end
    // PWM8 drives high while the low count byte is under the duty byte
    wr_reg(M0 + 5'h02, 8'h20);
    wr_reg(M0, 8'h06);
    @(posedge clock);
    #1;
    check8("out0", 8'h01, {7'h00, mod_out[0]});
    wr_reg(M0 + 5'h02, 8'h00);
    wr_reg(M0, 8'h00);
    $display("test mode_sweep done");
  endtask
  // Rising-edge capture, then a timer match with interrupt
  task automatic capture_timer();
    wr_reg(ADDR_COUNT_LO, 8'h37);
    wr_reg(M1, 8'h09);
    @(posedge clock);
    pin_drive <= 3'h2;
    repeat (4) @(posedge clock);
    rd_chk("cmp1 lo", M1 + 5'h01, 8'h37);
    rd_chk("status", ADDR_STATUS, 8'h04);
    wr_reg(M0 + 5'h01, 8'h05);
    wr_reg(M0, 8'h03);
    wr_reg(ADDR_COUNT_LO, 8'h00);
    wr_reg(ADDR_COUNT_HI, 8'h00);
    wr_reg(ADDR_MASK, 8'h02);
    wr_reg(ADDR_CTRL, 8'h09);
    repeat (6) @(posedge clock);
    wr_reg(ADDR_CTRL, 8'h08);
    repeat (4) @(posedge clock);
    #1;
    check8("irq", 8'h01, {7'h00, irq});
    rd_chk("status", ADDR_STATUS, 8'h02);
    check8("irq", 8'h00, {7'h00, irq});
    rd_chk("count lo", ADDR_COUNT_LO, 8'h08);
    $display("test capture_timer done");
  endtask
  // Hang guard
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    reset_values();
    sources();
    wrap_watchdog();
    kick();
    mode_sweep();
    capture_timer();
    // A second reset in mid-run must bring the watchdog defaults back
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    reset_values();
    tally_and_finish();
  end
endmodule // counter_array_tb_top
`default_nettype wire

// [tb/crossbar_model.sv]
// Far-side model: event sources and pin wire
`timescale 1ns/1ps
`default_nettype none
module crossbar_model import ca_pkg::*; (
  input wire logic clock, // System clock
  input wire logic rst, // Reset, active high
  input wire logic [NUM_MODULES-1:0] pin_drive, // Bench pin levels
  input wire logic [NUM_MODULES-1:0] module_out, // Module outputs
  input wire logic [NUM_MODULES-1:0] module_oe, // Module enables
  output logic timer0_overflow, // Pulse every 3rd cycle
  output logic external_count_input, // Rises every 4th cycle
  output logic ext_osc_clock, // Rises every 2nd cycle
  output logic [NUM_MODULES-1:0] module_in // Resolved pin levels
);
  logic [3:0] ph_q; // Phase 0..11, every period divides it
  // Free-running phase keeps each source strictly periodic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_q <= 4'h0;
    end else begin
      ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
    end
  end
  // Event sources for the time base
  assign timer0_overflow = (ph_q % 4'h3) == 4'h0;
  assign external_count_input = ph_q[1];
  assign ext_osc_clock = ph_q[0];
  // A driving module owns its pin, else the bench level shows
  assign module_in = (module_oe & module_out) | (~module_oe & pin_drive);
endmodule // crossbar_model
`default_nettype wire
